// ### rtl/udc_consts.svh
// constants for the up/down counter control block
// assumes pclk at 250 MHz
`ifndef UDC_CONSTS_SVH
`define UDC_CONSTS_SVH
`define UDC_ADDR_CTRL 12'h000
`define UDC_ADDR_STATUS 12'h004
`define UDC_ADDR_COUNT 12'h008
`define UDC_ADDR_LATCH 12'h00C
`define UDC_ADDR_CMP 12'h010
`define UDC_ADDR_PRESET 12'h014
`define UDC_CTRL_RESET 16'h0000
`define UDC_SCAN_DIV 16'h00F9
`define UDC_DIGITS 2'h3
`endif

// ### rtl/udc_pkg.sv
// types shared by the up/down counter control block
// assumes the constants header is included by the user
package udc_pkg;
  typedef enum logic [1:0] {udc_lvl_low, udc_lvl_high, udc_lvl_open} udc_lvl_type;
  typedef enum {udc_run, udc_load} udc_state_type;
  typedef struct packed {
    logic [3:0] digit;
    logic [3:0] bcd_out;
    logic bcd_oe_n;
    logic [6:0] seg;
    logic seg_oe_n;
  } udc_disp_type;
endpackage : udc_pkg

// ### rtl/udc_ctrl.sv
// control decode and load sequencing for a four decade bcd up/down counter
// assumes each 3-level pin is sensed as two comparator bits (hi, lo), asynchronous
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "udc_consts.svh"
module udc_ctrl (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, asynchronous
  input wire logic counter_preset_hi,
  input wire logic counter_preset_lo,
  input wire logic compare_preset_hi,
  input wire logic compare_preset_lo,
  input wire logic display_control_hi,
  input wire logic display_control_lo,
  input wire logic store_pin,
  input wire logic up_pin,
  input wire logic count_pin,
  input wire logic ext_scan,
  input wire logic [3:0] bcd_in,
  // display side
  output udc_pkg::udc_disp_type disp
);
  function automatic udc_pkg::udc_lvl_type lvl(input logic hi, input logic lo);
    if (hi) lvl = udc_pkg::udc_lvl_high;
    else if (lo) lvl = udc_pkg::udc_lvl_low;
    else lvl = udc_pkg::udc_lvl_open;
  endfunction : lvl

  // two flop synchronisers on every pin input
  logic [13:0] s1_reg, s2_reg;
  wire [13:0] raw = {counter_preset_hi, counter_preset_lo, compare_preset_hi, compare_preset_lo,
    display_control_hi, display_control_lo, store_pin, up_pin, count_pin, ext_scan, bcd_in};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 14'h0000;
      s2_reg <= 14'h0000;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  // decode only from the second stage
  udc_pkg::udc_lvl_type lc, lr, dc;
  assign lc = lvl(s2_reg[13], s2_reg[12]);
  assign lr = lvl(s2_reg[11], s2_reg[10]);
  assign dc = lvl(s2_reg[9], s2_reg[8]);
  wire store_s = s2_reg[7];
  wire up_s = s2_reg[6];
  wire cnt_s = s2_reg[5];
  wire scan_s = s2_reg[4];
  wire [3:0] bcd_s = s2_reg[3:0];
  wire lc_hi = (lc == udc_pkg::udc_lvl_high);
  wire lr_hi = (lr == udc_pkg::udc_lvl_high);
  wire lr_lo = (lr == udc_pkg::udc_lvl_low);
  wire lc_lo = (lc == udc_pkg::udc_lvl_low);

  // registers; ctrl bit0 is a software reset level (counter clear while set)
  logic [15:0] ctrl_reg, count_reg, count_next, latch_reg, cmp_reg, cmp_next;
  logic [15:0] div_reg;
  logic [1:0] dig_reg;
  logic cnt_d_reg, load_c_reg, load_r_reg;
  udc_pkg::udc_state_type state_reg;

  // scan tick: internal divider, or external scan falling edge outside loading
  logic scan_d_reg;
  wire int_tick = (div_reg == `UDC_SCAN_DIV);
  wire ext_tick = scan_d_reg & ~scan_s;
  wire loading = (state_reg == udc_pkg::udc_load);
  wire tick = loading ? int_tick : ext_tick;
  wire last_dig = (dig_reg == `UDC_DIGITS);
  wire rise = cnt_s & ~cnt_d_reg;

  // one decade up or down, returns digit and carry in bit 4
  function automatic logic [4:0] dec_step(input logic [3:0] d, input logic up);
    if (up) dec_step = (d == 4'h9) ? 5'h10 : {1'b0, d + 4'h1};
    else dec_step = (d == 4'h0) ? 5'h19 : {1'b0, d - 4'h1};
  endfunction : dec_step

  logic [4:0] carry;
  assign carry[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_dec
      wire [4:0] st = dec_step(count_reg[4*g+3:4*g], up_s);
      always_comb begin
        count_next[4*g+3:4*g] = carry[g] ? st[3:0] : count_reg[4*g+3:4*g];
      end
      assign carry[g+1] = carry[g] & st[4];
    end
  endgenerate

  // apb decode
  wire wr = psel & penable & pwrite;
  wire hit_ctrl = (paddr == `UDC_ADDR_CTRL);
  wire hit_stat = (paddr == `UDC_ADDR_STATUS);
  wire hit_cnt = (paddr == `UDC_ADDR_COUNT);
  wire hit_lat = (paddr == `UDC_ADDR_LATCH);
  wire hit_cmp = (paddr == `UDC_ADDR_CMP);
  wire hit_pre = (paddr == `UDC_ADDR_PRESET);
  wire mapped = hit_ctrl | hit_stat | hit_cnt | hit_lat | hit_cmp | hit_pre;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  wire [31:0] status = {23'h000000, dig_reg, loading, dc, lr, lc};
  always_comb begin
    if (hit_ctrl) prdata = {16'h0000, ctrl_reg};
    else if (hit_stat) prdata = status;
    else if (hit_cnt) prdata = {16'h0000, count_reg};
    else if (hit_lat) prdata = {16'h0000, latch_reg};
    else if (hit_cmp) prdata = {16'h0000, cmp_reg};
    else prdata = 32'h00000000;
  end

  // software reset acts like the reset pin: counter held at zero
  wire sw_clr = ctrl_reg[0];
  wire [3:0] load_digit = sw_clr ? 4'h0 : bcd_s;
  wire dig_wr = loading & tick;
  logic [15:0] ins;
  always_comb begin
    ins = count_reg;
    ins[4*(3-dig_reg)+:4] = load_digit;
  end
  logic [15:0] rins;
  always_comb begin
    rins = cmp_reg;
    rins[4*(3-dig_reg)+:4] = load_digit;
  end
  assign cmp_next = (dig_wr & load_r_reg) ? rins : cmp_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
    end else if (sw_clr) begin
      count_reg <= 16'h0000;
    end else if (dig_wr & load_c_reg) begin
      count_reg <= ins;
    end else if (!(loading & load_c_reg) && rise) begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `UDC_CTRL_RESET;
      latch_reg <= 16'h0000;
      cmp_reg <= 16'h0000;
      cnt_d_reg <= 1'b0;
      scan_d_reg <= 1'b0;
    end else begin
      if (wr & hit_ctrl) ctrl_reg <= pwdata[15:0];
      if (!store_s) latch_reg <= count_reg;
      cmp_reg <= cmp_next;
      cnt_d_reg <= cnt_s;
      scan_d_reg <= scan_s;
    end
  end

  // load sequencer and multiplex digit counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= udc_pkg::udc_run;
      dig_reg <= 2'h0;
      div_reg <= 16'h0000;
      load_c_reg <= 1'b0;
      load_r_reg <= 1'b0;
    end else begin
      div_reg <= (int_tick | lr_lo) ? 16'h0000 : div_reg + 16'h0001;
      case (state_reg)
        udc_pkg::udc_run: begin
          if (lc_hi | lr_hi) begin
            state_reg <= udc_pkg::udc_load;
            dig_reg <= 2'h0;
            div_reg <= 16'h0000;
            load_c_reg <= lc_hi;
            load_r_reg <= lr_hi;
          end else if (lr_lo) begin
            dig_reg <= 2'h0;
          end else if (tick) begin
            dig_reg <= dig_reg + 2'h1;
          end
        end
        udc_pkg::udc_load: begin
          if (tick) begin
            dig_reg <= dig_reg + 2'h1;
            if (last_dig) begin
              load_c_reg <= lc_hi;
              load_r_reg <= lr_hi;
              if (!(lc_hi | lr_hi)) state_reg <= udc_pkg::udc_run;
            end
          end
        end
        default: state_reg <= udc_pkg::udc_run;
      endcase
    end
  end

  // display: leading zero blanking, segment decode
  wire [3:0] cur = latch_reg[4*(3-dig_reg)+:4];
  logic [3:0] hi_nz;
  assign hi_nz[3] = 1'b0;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_lz
      assign hi_nz[g] = hi_nz[g+1] | (latch_reg[4*(g+1)+:4] != 4'h0);
    end
  endgenerate
  wire is_lsd = (dig_reg == `UDC_DIGITS);
  wire blank = (cur == 4'h0) & ~hi_nz[3-dig_reg] & ~is_lsd & (dc != udc_pkg::udc_lvl_low);
  logic [6:0] seg;
  always_comb begin
    case (cur)
      4'h0: seg = 7'h3F;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5B;
      4'h3: seg = 7'h4F;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6D;
      4'h6: seg = 7'h7D;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7F;
      4'h9: seg = 7'h6F;
      default: seg = 7'h03; // a and b lit so any unblanked digit is detectable
    endcase
  end
  wire disp_off = lr_lo;
  wire port_drive = (lc == udc_pkg::udc_lvl_open) & (lr == udc_pkg::udc_lvl_open) & ~loading;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp <= '{digit: 4'h0, bcd_out: 4'h0, bcd_oe_n: 1'b1, seg: 7'h00, seg_oe_n: 1'b1};
    end else begin
      disp.digit <= (disp_off | (~loading & scan_s)) ? 4'h0 : (4'h8 >> dig_reg);
      disp.bcd_out <= cur;
      disp.bcd_oe_n <= ~port_drive | lc_lo | disp_off;
      disp.seg <= blank ? 7'h00 : seg;
      disp.seg_oe_n <= disp_off | (dc == udc_pkg::udc_lvl_high);
    end
  end
endmodule : udc_ctrl

// ### test/udc_ctrl_chk.sv
// port checker for the counter control block
// assumes it is bound to udc_ctrl and sees its ports only
`timescale 1ns/1ps
module udc_ctrl_chk (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // pins and display
  input wire logic counter_preset_hi,
  input wire logic counter_preset_lo,
  input wire logic compare_preset_hi,
  input wire logic compare_preset_lo,
  input wire logic display_control_hi,
  input wire udc_pkg::udc_disp_type disp
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // six cycles covers the two sync flops plus the output register
  zero_wait_a: assert property (psel && penable |-> pready) else $error("apb wait seen");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  display_off_a: assert property (
    (compare_preset_lo && !compare_preset_hi)[*6] |-> disp.seg_oe_n && disp.bcd_oe_n)
    else $error("display not off");
  port_float_a: assert property (
    (counter_preset_lo && !counter_preset_hi)[*6] |-> disp.bcd_oe_n) else $error("port driven");
  seg_off_a: assert property (
    display_control_hi[*6] |-> disp.seg_oe_n) else $error("segments still driven");
  lit_digit_a: assert property (
    !disp.seg_oe_n && disp.seg != 7'h00 |-> disp.seg[0] || disp.seg[1]) else $error("no a or b");
  reset_idle_a: assert property (
    $rose(presetn) |-> disp.bcd_oe_n && disp.seg_oe_n && disp.digit == 4'h0)
    else $error("outputs active after reset");
  digit_onehot_a: assert property (
    $onehot0(disp.digit)) else $error("digit strobe not one-hot");
endmodule : udc_ctrl_chk

// ### test/udc_switch_model.sv
// thumbwheel bank and center-off switches in front of the control block
// assumes one-hot digit strobes pick one decade; unpicked lines read 0 through pull-downs
`timescale 1ns/1ps
module udc_switch_model (
  // settings
  input wire logic [15:0] wheel,
  input wire udc_pkg::udc_lvl_type lc_lvl,
  input wire udc_pkg::udc_lvl_type lr_lvl,
  input wire udc_pkg::udc_lvl_type dc_lvl,
  input wire udc_pkg::udc_disp_type disp,
  // pins
  output logic counter_preset_hi,
  output logic counter_preset_lo,
  output logic compare_preset_hi,
  output logic compare_preset_lo,
  output logic display_control_hi,
  output logic display_control_lo,
  output logic [3:0] bcd_in
);
  // a switch sits in one position, never passing high on its way
  assign counter_preset_hi = lc_lvl == udc_pkg::udc_lvl_high;
  assign counter_preset_lo = lc_lvl == udc_pkg::udc_lvl_low;
  assign compare_preset_hi = lr_lvl == udc_pkg::udc_lvl_high;
  assign compare_preset_lo = lr_lvl == udc_pkg::udc_lvl_low;
  assign display_control_hi = dc_lvl == udc_pkg::udc_lvl_high;
  assign display_control_lo = dc_lvl == udc_pkg::udc_lvl_low;
  assign bcd_in = disp.digit[3] ? wheel[15:12] : disp.digit[2] ? wheel[11:8] :
    disp.digit[1] ? wheel[7:4] : disp.digit[0] ? wheel[3:0] : 4'h0;
endmodule : udc_switch_model

// ### test/udc_ctrl_tb_top.sv
// self-checking bench for the counter control block
// assumes apb answers in the access phase and pins settle within eight cycles
`timescale 1ns/1ps
module udc_ctrl_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic store_pin = 1'b1, up_pin = 1'b1, count_pin = 1'b0, ext_scan = 1'b0;
  logic counter_preset_hi, counter_preset_lo, compare_preset_hi, compare_preset_lo;
  logic display_control_hi, display_control_lo;
  logic [3:0] bcd_in;
  logic [15:0] wheel = 16'h1299;
  udc_pkg::udc_lvl_type lc_lvl = udc_pkg::udc_lvl_open, lr_lvl = udc_pkg::udc_lvl_open;
  udc_pkg::udc_lvl_type dc_lvl = udc_pkg::udc_lvl_open;
  udc_pkg::udc_disp_type disp;
  int n_fail = 0, comparisons = 0;
  typedef struct {logic [11:0] a; logic [31:0] m; logic [31:0] d; logic e;} udc_row_type;
  // status digit index follows the scan ticks, so it is masked off
  udc_row_type rows [7] = '{'{12'h000, 32'hFFFF, 32'h0, 1'b0}, '{12'h004, 32'h7F, 32'h2A, 1'b0},
    '{12'h008, 32'hFFFF, 32'h0, 1'b0}, '{12'h00C, 32'hFFFF, 32'h0, 1'b0},
    '{12'h010, 32'hFFFF, 32'h0, 1'b0}, '{12'h014, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{12'h018, 32'hFFFFFFFF, 32'h0, 1'b1}};
  always #2 pclk = ~pclk;
  udc_ctrl u_udc_ctrl (.*);
  udc_switch_model u_udc_switch_model (.*);
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {1'b1, 1'b0, a, w, wd};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_fail++;
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd & 32'hFFFF, exp);
  endtask : rdc
  task pulse(input logic up, input int n);
    up_pin <= up;
    repeat (n) begin
      wait_cyc(4);
      count_pin <= 1'b1;
      wait_cyc(4);
      count_pin <= 1'b0;
    end
    wait_cyc(8);
  endtask : pulse
  initial begin
    wait_cyc(20);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b0, 32'h0);
      chk(rd & rows[i].m, rows[i].d);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    for (int l = 0; l < 3; l++) begin
      lc_lvl <= udc_pkg::udc_lvl_type'(l);
      lr_lvl <= udc_pkg::udc_lvl_type'(l);
      dc_lvl <= udc_pkg::udc_lvl_type'(l);
      wait_cyc(8);
      apb(12'h004, 1'b0, 32'h0);
      chk(rd & 32'h3F, 32'h15 * l);
    end
    // the short high pulse must still run one full msd..lsd pass
    wait_cyc(1300);
    rdc(12'h008, 32'h1299);
    rdc(12'h010, 32'h1299);
    pulse(1'b1, 3);
    rdc(12'h008, 32'h1302);
    rdc(12'h00C, 32'h0);
    store_pin <= 1'b0;
    wait_cyc(8);
    store_pin <= 1'b1;
    pulse(1'b0, 5);
    rdc(12'h00C, 32'h1302);
    apb(12'h008, 1'b1, 32'hFFFF);
    rdc(12'h008, 32'h1297);
    for (int i = 0; i < 1200 && disp.digit !== 4'h8; i++) @(posedge pclk);
    chk({27'h0, disp.bcd_oe_n, disp.bcd_out}, 32'h1);
    chk({24'h0, disp.seg_oe_n, disp.seg}, 32'h06);
    // one external scan pulse: digits dark while high, next digit after the fall
    ext_scan <= 1'b1;
    wait_cyc(4);
    chk({28'h0, disp.digit}, 32'h0);
    ext_scan <= 1'b0;
    wait_cyc(6);
    chk({28'h0, disp.digit}, 32'h4);
    chk({27'h0, disp.bcd_oe_n, disp.bcd_out}, 32'h3);
    chk({25'h0, disp.seg}, 32'h4F);
    apb(12'h020, 1'b1, 32'hFFFF);
    chk({31'h0, err}, 32'h1);
    apb(12'h000, 1'b1, 32'h1);
    rdc(12'h000, 32'h1);
    rdc(12'h008, 32'h0);
    apb(12'h000, 1'b1, 32'h0);
    pulse(1'b1, 2);
    rdc(12'h008, 32'h2);
    store_pin <= 1'b0;
    wait_cyc(8);
    store_pin <= 1'b1;
    lr_lvl <= udc_pkg::udc_lvl_low;
    wait_cyc(8);
    chk({28'h0, disp.digit}, 32'h0);
    lr_lvl <= udc_pkg::udc_lvl_open;
    wait_cyc(8);
    chk({21'h0, disp.digit, disp.seg}, 32'h400);
    dc_lvl <= udc_pkg::udc_lvl_low;
    wait_cyc(8);
    chk({21'h0, disp.digit, disp.seg}, 32'h43F);
    dc_lvl <= udc_pkg::udc_lvl_open;
    presetn <= 1'b0;
    wait_cyc(2);
    presetn <= 1'b1;
    rdc(12'h008, 32'h0);
    end_sim;
  end
  initial begin
    wait_cyc(20000);
    n_fail++;
    end_sim;
  end
endmodule : udc_ctrl_tb_top
bind udc_ctrl udc_ctrl_chk u_udc_ctrl_chk (.*);
